/* adc_digital_path_config_regs.sv */
`timescale 1ns/1ps
module adc_digital_path_config_regs (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_enable_n,
  input  wire logic       serial_data_in,
  input  wire logic       fast_overrange_b,
  output logic            serial_readback_pin,
  output logic            serial_readback_oe,
  output logic            performance_setting_top,
  output logic [7:0]      overrange_level,
  output logic            overrange_b_route,
  output logic            filter_highpass,
  output logic            filter_select_forbidden,
  output logic [2:0]      zone_select,
  output logic            zone_select_enabled,
  output logic            zone_select_valid,
  output logic            offset_binary,
  output logic            gain_enable,
  output logic [6:0]      applied_gain_code
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Index 0 is the serial clock, 1 the enable, 2 the data line. Only the second
  // stage is read, so a metastable first stage never reaches the decode.
  wire  [2:0] pin_raw = {serial_data_in, ~serial_enable_n, serial_clk};
  logic [2:0] sync_meta;
  logic [2:0] sync_out;
  logic       sclk_prev;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_meta[gi] <= 1'b0;
          sync_out[gi]  <= 1'b0;
        end
        else
        begin
          sync_meta[gi] <= pin_raw[gi];
          sync_out[gi]  <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // Edge detection works on the settled copy of the serial clock.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_prev <= 1'b0;
    end
    else
    begin
      sclk_prev <= sync_out[0];
    end
  end

  wire sclk_rise    = sync_out[0] & ~sclk_prev;
  wire sclk_fall    = ~sync_out[0] & sclk_prev;
  wire frame_active = sync_out[1];

  // ---------------------------------------------------------------------------
  // Serial frame engine
  // ---------------------------------------------------------------------------
  wire       wr_strobe;
  wire       read_phase;
  wire [1:0] page_sel;
  wire [7:0] reg_addr;
  wire [7:0] wr_data;
  wire       miso_bit;
  wire [7:0] rd_data;

  spi_frame_engine u_frame (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .frame_active (frame_active),
    .sclk_rise    (sclk_rise),
    .sclk_fall    (sclk_fall),
    .mosi_bit     (sync_out[2]),
    .rd_data      (rd_data),
    .wr_strobe    (wr_strobe),
    .read_phase   (read_phase),
    .page_sel     (page_sel),
    .reg_addr     (reg_addr),
    .wr_data      (wr_data),
    .miso_bit     (miso_bit)
  );

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Page and offset both must match; a page code outside the three known ones
  // decodes to nothing, so such writes vanish and reads return zero.
  wire on_master = (page_sel == adc_cfg_pkg::PAGE_MASTER);
  wire on_conv   = (page_sel == adc_cfg_pkg::PAGE_CONVERTER);
  wire on_main   = (page_sel == adc_cfg_pkg::PAGE_MAIN_DIG);

  wire hit_perf   = on_master && (reg_addr == adc_cfg_pkg::OFS_PERFORMANCE_TOP_BIT);
  wire hit_route  = on_master && (reg_addr == adc_cfg_pkg::OFS_OVERRANGE_ROUTE);
  wire hit_level  = on_conv   && (reg_addr == adc_cfg_pkg::OFS_OVERRANGE_THRESHOLD);
  wire hit_apply  = on_main   && (reg_addr == adc_cfg_pkg::OFS_DIGITAL_APPLY_CTRL);
  wire hit_decim  = on_main   && (reg_addr == adc_cfg_pkg::OFS_DECIM_FILTER_SEL);
  wire hit_zone   = on_main   && (reg_addr == adc_cfg_pkg::OFS_SAMPLING_ZONE_SEL);
  wire hit_coding = on_main   && (reg_addr == adc_cfg_pkg::OFS_OUTPUT_CODING_SEL);
  wire hit_gain   = on_main   && (reg_addr == adc_cfg_pkg::OFS_GAIN_CODE);
  wire hit_cod_en = on_main   && (reg_addr == adc_cfg_pkg::OFS_CODING_CTRL_ENABLE);
  wire hit_dec_en = on_main   && (reg_addr == adc_cfg_pkg::OFS_DECIM_CTRL_ENABLE);
  wire hit_zon_en = on_main   && (reg_addr == adc_cfg_pkg::OFS_ZONE_CTRL_ENABLE);
  wire hit_gai_en = on_main   && (reg_addr == adc_cfg_pkg::OFS_GAIN_ENABLE);

  // ---------------------------------------------------------------------------
  // Master and converter page registers, effective at once
  // ---------------------------------------------------------------------------
  logic       perf_top;
  logic       route_b;
  logic       route_one;
  logic [7:0] level;

  // Only documented field bits are stored; reserved positions are dropped.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perf_top  <= 1'b0;
      route_b   <= 1'b0;
      route_one <= 1'b0;
      level     <= adc_cfg_pkg::RST_OVERRANGE_LEVEL;
    end
    else if (wr_strobe)
    begin
      if (hit_perf)
      begin
        perf_top <= wr_data[adc_cfg_pkg::PERF_TOP_POS];
      end
      if (hit_route)
      begin
        route_b   <= wr_data[adc_cfg_pkg::ROUTE_B_POS];
        route_one <= wr_data[adc_cfg_pkg::ROUTE_ONE_POS];
      end
      if (hit_level)
      begin
        level <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Main digital page: staged copies written by the host
  // ---------------------------------------------------------------------------
  logic       apply_bit;
  logic       stg_dec_top;
  logic [2:0] stg_dec_low;
  logic [2:0] stg_zone;
  logic       stg_cod_sel;
  logic [6:0] stg_gain;
  logic       stg_cod_en;
  logic       stg_dec_en;
  logic       stg_zon_en;
  logic       stg_gai_en;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      apply_bit   <= 1'b0;
      stg_dec_top <= 1'b0;
      stg_dec_low <= adc_cfg_pkg::RST_DECIM_LOW;
      stg_zone    <= 3'h0;
      stg_cod_sel <= 1'b0;
      stg_gain    <= 7'h00;
      stg_cod_en  <= 1'b0;
      stg_dec_en  <= 1'b0;
      stg_zon_en  <= 1'b0;
      stg_gai_en  <= 1'b0;
    end
    else if (wr_strobe)
    begin
      if (hit_apply)
      begin
        apply_bit <= wr_data[adc_cfg_pkg::APPLY_POS];
      end
      if (hit_decim)
      begin
        stg_dec_top <= wr_data[adc_cfg_pkg::DECIM_TOP_POS];
        stg_dec_low <= wr_data[adc_cfg_pkg::DECIM_LOW_HI:0];
      end
      if (hit_zone)
      begin
        stg_zone <= wr_data[adc_cfg_pkg::ZONE_HI:0];
      end
      if (hit_coding)
      begin
        stg_cod_sel <= wr_data[adc_cfg_pkg::CODING_SEL_POS];
      end
      if (hit_gain)
      begin
        stg_gain <= wr_data[adc_cfg_pkg::GAIN_HI:0];
      end
      if (hit_cod_en)
      begin
        stg_cod_en <= wr_data[adc_cfg_pkg::CODING_EN_POS];
      end
      if (hit_dec_en)
      begin
        stg_dec_en <= wr_data[adc_cfg_pkg::DECIM_EN_POS];
      end
      if (hit_zon_en)
      begin
        stg_zon_en <= wr_data[adc_cfg_pkg::ZONE_EN_POS];
      end
      if (hit_gai_en)
      begin
        stg_gai_en <= wr_data[adc_cfg_pkg::GAIN_EN_POS];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Main digital page: active copies that steer the data path
  // ---------------------------------------------------------------------------
  // The copy fires on the falling half of the pulse, the write that clears a
  // set apply bit. Writing one alone changes nothing, so a host that stops
  // half way keeps the old settings running.
  wire apply_fire = wr_strobe && hit_apply && apply_bit &&
                    !wr_data[adc_cfg_pkg::APPLY_POS];

  logic       act_dec_top;
  logic [2:0] act_dec_low;
  logic [2:0] act_zone;
  logic       act_cod_sel;
  logic [6:0] act_gain;
  logic       act_cod_en;
  logic       act_dec_en;
  logic       act_zon_en;
  logic       act_gai_en;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_dec_top <= 1'b0;
      act_dec_low <= adc_cfg_pkg::RST_DECIM_LOW;
      act_zone    <= 3'h0;
      act_cod_sel <= 1'b0;
      act_gain    <= 7'h00;
      act_cod_en  <= 1'b0;
      act_dec_en  <= 1'b0;
      act_zon_en  <= 1'b0;
      act_gai_en  <= 1'b0;
    end
    else if (apply_fire)
    begin
      act_dec_top <= stg_dec_top;
      act_dec_low <= stg_dec_low;
      act_zone    <= stg_zone;
      act_cod_sel <= stg_cod_sel;
      act_gain    <= stg_gain;
      act_cod_en  <= stg_cod_en;
      act_dec_en  <= stg_dec_en;
      act_zon_en  <= stg_zon_en;
      act_gai_en  <= stg_gai_en;
    end
  end

  // ---------------------------------------------------------------------------
  // Readback: stored values of readable fields, staged copies on the main page; write-only bits read zero
  // ---------------------------------------------------------------------------
  wire [7:0] rd_route  = {2'h0, route_one, 5'h00};
  wire [7:0] rd_apply  = {7'h00, apply_bit};
  wire [7:0] rd_decim  = {3'h0, stg_dec_top, 1'b0, stg_dec_low};
  wire [7:0] rd_zone   = {5'h00, stg_zone};
  wire [7:0] rd_coding = {7'h00, stg_cod_sel};
  wire [7:0] rd_gain   = {1'b0, stg_gain};
  wire [7:0] rd_cod_en = {2'h0, stg_cod_en, 5'h00};
  wire [7:0] rd_dec_en = {4'h0, stg_dec_en, 3'h0};
  wire [7:0] rd_zon_en = {stg_zon_en, 7'h00};
  wire [7:0] rd_gai_en = {7'h00, stg_gai_en};

  assign rd_data = hit_route  ? rd_route  :
                   hit_level  ? level     :
                   hit_apply  ? rd_apply  :
                   hit_decim  ? rd_decim  :
                   hit_zone   ? rd_zone   :
                   hit_coding ? rd_coding :
                   hit_gain   ? rd_gain   :
                   hit_cod_en ? rd_cod_en :
                   hit_dec_en ? rd_dec_en :
                   hit_zon_en ? rd_zon_en :
                   hit_gai_en ? rd_gai_en :
                   8'h00;

  // ---------------------------------------------------------------------------
  // Readback pin
  // ---------------------------------------------------------------------------
  // The overrange route takes the pin over entirely, so register reads return
  // nothing useful while it is set; the host must clear it first to read back.
  wire next_pin = route_b ? fast_overrange_b : (read_phase & miso_bit);
  wire next_oe  = route_b | read_phase;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_readback_pin <= 1'b0;
      serial_readback_oe  <= 1'b0;
    end
    else
    begin
      serial_readback_pin <= next_pin;
      serial_readback_oe  <= next_oe;
    end
  end

  // ---------------------------------------------------------------------------
  // Settings presented to the data path
  // ---------------------------------------------------------------------------
  wire [3:0] dec_sel = {act_dec_top, act_dec_low};

  assign performance_setting_top = perf_top;
  assign overrange_level         = level;
  assign overrange_b_route       = route_b;
  // Selector ignored while decimation control is off: low-pass by two.
  assign filter_highpass         = act_dec_en && (dec_sel == adc_cfg_pkg::DECIM_SEL_HIGHPASS);
  assign filter_select_forbidden = act_dec_en && (dec_sel != adc_cfg_pkg::DECIM_SEL_LOWPASS) &&
                                   (dec_sel != adc_cfg_pkg::DECIM_SEL_HIGHPASS);
  assign zone_select             = act_zone;
  assign zone_select_enabled     = act_zon_en;
  assign zone_select_valid       = act_zon_en && (act_zone <= adc_cfg_pkg::ZONE_LAST_VALID);
  assign offset_binary           = act_cod_en && act_cod_sel;
  assign gain_enable             = act_gai_en;
  // Code 32 is unity, so a disabled gain stage presents 0 dB downstream.
  assign applied_gain_code       = act_gai_en ? act_gain : adc_cfg_pkg::GAIN_UNITY_CODE;

endmodule : adc_digital_path_config_regs

/* adc_cfg_pkg.sv */
package adc_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------------------
  localparam int         FRAME_BITS    = 24;
  localparam int         HEADER_BITS   = 16;
  localparam logic [4:0] CNT_HEADER_END = 5'h0F;
  localparam logic [4:0] CNT_DATA_START = 5'h10;
  localparam logic [4:0] CNT_FRAME_END  = 5'h17;
  localparam logic [4:0] CNT_SATURATE   = 5'h18;
  localparam int         RW_POS        = 14;
  localparam int         PAGE_HI       = 8;
  localparam int         PAGE_LO       = 7;

  // ---------------------------------------------------------------------------
  // Page select codes carried in the frame, and the pages they stand for
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  PAGE_MASTER     = 2'h0;
  localparam logic [1:0]  PAGE_CONVERTER  = 2'h1;
  localparam logic [1:0]  PAGE_MAIN_DIG   = 2'h2;
  localparam logic [15:0] PAGE_ID_MASTER    = 16'h0080;
  localparam logic [15:0] PAGE_ID_CONVERTER = 16'h000F;
  localparam logic [15:0] PAGE_ID_MAIN_DIG  = 16'h6800;

  // ---------------------------------------------------------------------------
  // Register offsets within their pages
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_PERFORMANCE_TOP_BIT = 8'h56;
  localparam logic [7:0] OFS_OVERRANGE_ROUTE     = 8'h59;
  localparam logic [7:0] OFS_OVERRANGE_THRESHOLD = 8'h5F;
  localparam logic [7:0] OFS_DIGITAL_APPLY_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DECIM_FILTER_SEL    = 8'h41;
  localparam logic [7:0] OFS_SAMPLING_ZONE_SEL   = 8'h42;
  localparam logic [7:0] OFS_OUTPUT_CODING_SEL   = 8'h43;
  localparam logic [7:0] OFS_GAIN_CODE           = 8'h44;
  localparam logic [7:0] OFS_CODING_CTRL_ENABLE  = 8'h4B;
  localparam logic [7:0] OFS_DECIM_CTRL_ENABLE   = 8'h4D;
  localparam logic [7:0] OFS_ZONE_CTRL_ENABLE    = 8'h4E;
  localparam logic [7:0] OFS_GAIN_ENABLE         = 8'h52;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int PERF_TOP_POS     = 2;
  localparam int ROUTE_B_POS      = 7;
  localparam int ROUTE_ONE_POS    = 5;
  localparam int APPLY_POS        = 0;
  localparam int DECIM_TOP_POS    = 4;
  localparam int DECIM_LOW_HI     = 2;
  localparam int ZONE_HI          = 2;
  localparam int CODING_SEL_POS   = 0;
  localparam int GAIN_HI          = 6;
  localparam int CODING_EN_POS    = 5;
  localparam int DECIM_EN_POS     = 3;
  localparam int ZONE_EN_POS      = 7;
  localparam int GAIN_EN_POS      = 0;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_OVERRANGE_LEVEL = 8'hE3;
  localparam logic [2:0] RST_DECIM_LOW       = 3'h2;
  localparam logic [3:0] DECIM_SEL_LOWPASS   = 4'hA;
  localparam logic [3:0] DECIM_SEL_HIGHPASS  = 4'hE;
  localparam logic [2:0] ZONE_LAST_VALID     = 3'h2;
  localparam logic [6:0] GAIN_UNITY_CODE     = 7'h20;

endpackage : adc_cfg_pkg

/* spi_frame_engine.sv */
`timescale 1ns/1ps
// Serial frame engine: byte 0 is read flag and page, byte 1 the offset, byte 2 the data.
module spi_frame_engine (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       frame_active,
  input  wire logic       sclk_rise,
  input  wire logic       sclk_fall,
  input  wire logic       mosi_bit,
  input  wire logic [7:0] rd_data,
  output logic            wr_strobe,
  output logic            read_phase,
  output logic [1:0]      page_sel,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  output logic            miso_bit
);

  logic [4:0]  bit_cnt;
  logic [22:0] shift_in;
  logic        rd_mode;
  logic [7:0]  shift_out;

  wire header_done = sclk_rise && (bit_cnt == adc_cfg_pkg::CNT_HEADER_END);
  wire data_done   = sclk_rise && (bit_cnt == adc_cfg_pkg::CNT_FRAME_END);
  wire past_header = (bit_cnt >= adc_cfg_pkg::CNT_DATA_START);

  // ---------------------------------------------------------------------------
  // Input shifting; bits past the third byte are ignored by saturating the count.
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt  <= 5'h00;
      shift_in <= 23'h000000;
    end
    else if (!frame_active)
    begin
      bit_cnt  <= 5'h00;
      shift_in <= 23'h000000;
    end
    else if (sclk_rise)
    begin
      shift_in <= {shift_in[21:0], mosi_bit};
      if (bit_cnt != adc_cfg_pkg::CNT_SATURATE)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Header capture after the sixteenth bit; the write fires on the twenty-fourth.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_mode   <= 1'b0;
      page_sel  <= 2'h0;
      reg_addr  <= 8'h00;
      wr_data   <= 8'h00;
      wr_strobe <= 1'b0;
    end
    else
    begin
      wr_strobe <= frame_active && data_done && !rd_mode;
      if (!frame_active)
      begin
        rd_mode <= 1'b0;
      end
      else if (header_done)
      begin
        rd_mode  <= shift_in[adc_cfg_pkg::RW_POS];
        page_sel <= shift_in[adc_cfg_pkg::PAGE_HI:adc_cfg_pkg::PAGE_LO];
        reg_addr <= {shift_in[6:0], mosi_bit};
      end
      if (frame_active && data_done)
      begin
        wr_data <= {shift_in[6:0], mosi_bit};
      end
    end
  end

  // Readback leaves MSB first, changing on falling clock edges of the data byte.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_out <= 8'h00;
    end
    else if (!frame_active)
    begin
      shift_out <= 8'h00;
    end
    else if (sclk_fall && rd_mode && (bit_cnt == adc_cfg_pkg::CNT_DATA_START))
    begin
      shift_out <= rd_data;
    end
    else if (sclk_fall && rd_mode && past_header)
    begin
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  assign read_phase = frame_active && rd_mode && past_header;
  assign miso_bit   = shift_out[7];

endmodule : spi_frame_engine

/* adc_cfg_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port relations of the configuration bank
// ----------------------------------------
module adc_cfg_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       serial_enable_n,
  input wire logic       fast_overrange_b,
  input wire logic       serial_readback_pin,
  input wire logic       serial_readback_oe,
  input wire logic [7:0] overrange_level,
  input wire logic       overrange_b_route,
  input wire logic       filter_highpass,
  input wire logic       filter_select_forbidden,
  input wire logic [2:0] zone_select,
  input wire logic       zone_select_enabled,
  input wire logic       zone_select_valid,
  input wire logic       offset_binary,
  input wire logic       gain_enable,
  input wire logic [6:0] applied_gain_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Routed flag follows channel B with one cycle of lag.
  property p_route_pin;
    $past(overrange_b_route) |-> serial_readback_pin == $past(fast_overrange_b);
  endproperty
  a_route_pin: assert property (p_route_pin) else $error("routed flag lag wrong");
  property p_route_oe;
    $past(overrange_b_route) |-> serial_readback_oe;
  endproperty
  a_route_oe: assert property (p_route_oe) else $error("routed pin not driven");
  property p_filter_excl;
    filter_highpass |-> !filter_select_forbidden;
  endproperty
  a_filter_excl: assert property (p_filter_excl) else $error("filter flags clash");
  property p_zone_valid;
    zone_select_valid |-> zone_select_enabled && zone_select <= 3'h2;
  endproperty
  a_zone_valid: assert property (p_zone_valid) else $error("zone valid wrong");
  property p_gain_unity;
    !gain_enable |-> applied_gain_code == 7'h20;
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("gain not unity");
  // A quiet port means level, coding, gain and zone may not move; a missed stage would show here.
  property p_quiet;
    serial_enable_n [*8] |=> $stable(overrange_level) && $stable(offset_binary)
      && $stable(applied_gain_code) && $stable(zone_select);
  endproperty
  a_quiet: assert property (p_quiet) else $error("setting moved while idle");
  property p_oe_idle;
    !overrange_b_route && serial_enable_n [*8] |-> !serial_readback_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin driven while idle");
  property p_pin_idle;
    !serial_readback_oe |-> !serial_readback_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("undriven pin not low");
endmodule : adc_cfg_checker

bind adc_digital_path_config_regs adc_cfg_checker i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .serial_enable_n(serial_enable_n), .fast_overrange_b(fast_overrange_b),
  .serial_readback_pin(serial_readback_pin), .serial_readback_oe(serial_readback_oe),
  .overrange_level(overrange_level), .overrange_b_route(overrange_b_route),
  .filter_highpass(filter_highpass), .filter_select_forbidden(filter_select_forbidden),
  .zone_select(zone_select), .zone_select_enabled(zone_select_enabled),
  .zone_select_valid(zone_select_valid), .offset_binary(offset_binary),
  .gain_enable(gain_enable), .applied_gain_code(applied_gain_code));

/* host_serial_model.sv */
`timescale 1ns/1ps
// Host on the serial port; half periods of 8 core cycles leave room for sync.
module host_serial_model (
  input  wire logic ref_clk,
  input  wire logic serial_readback_pin,
  output logic      serial_clk,
  output logic      serial_enable_n,
  output logic      serial_data_in
);
  initial
  begin
    serial_clk = 1'b0;
    serial_enable_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // One whole frame; readback bits are taken at the rising serial edge.
  task automatic xfer(input logic rd, input logic [1:0] pg, input logic [7:0] ofs, wd,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 5'h00, pg, ofs, wd};
    q = 8'h00;
    serial_enable_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      serial_data_in <= f[i];
      repeat (8) @(posedge ref_clk);
      if (i < 8) q = {q[6:0], serial_readback_pin};
      serial_clk <= 1'b1;
      repeat (8) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    serial_enable_n <= 1'b1;
    serial_data_in <= ~f[0];
    repeat (8) @(posedge ref_clk);
  endtask : xfer
endmodule : host_serial_model

/* adc_digital_path_config_regs_test.sv */
`timescale 1ns/1ps
module adc_digital_path_config_regs_test;
  typedef struct packed {logic [1:0] pg; logic [7:0] ofs, wd, rd;} row_t;
  logic ref_clk, rst_n, fob, pin, oe, perf, route, hp, forb, zen, zval, ob, gen;
  wire sclk, sen_n, sdi;
  logic [7:0] level, q;
  logic [2:0] zone;
  logic [6:0] gain;
  int num_errors, checked;
  // Main page writes land in staging, the others act at once; readback shows what was staged.
  row_t rows[12] = '{'{2'h1, 8'h5F, 8'h55, 8'h55}, '{2'h0, 8'h59, 8'h20, 8'h20},
    '{2'h0, 8'h56, 8'h04, 8'h00}, '{2'h2, 8'h41, 8'hFE, 8'h16}, '{2'h2, 8'h42, 8'h02, 8'h02},
    '{2'h2, 8'h43, 8'h01, 8'h01}, '{2'h2, 8'h44, 8'h7F, 8'h7F}, '{2'h2, 8'h4B, 8'h20, 8'h20},
    '{2'h2, 8'h4D, 8'h08, 8'h08}, '{2'h2, 8'h4E, 8'h80, 8'h80}, '{2'h2, 8'h52, 8'h01, 8'h01},
    '{2'h3, 8'h10, 8'hAA, 8'h00}};
  adc_digital_path_config_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(sclk),
    .serial_enable_n(sen_n), .serial_data_in(sdi), .fast_overrange_b(fob),
    .serial_readback_pin(pin), .serial_readback_oe(oe), .performance_setting_top(perf),
    .overrange_level(level), .overrange_b_route(route), .filter_highpass(hp),
    .filter_select_forbidden(forb), .zone_select(zone), .zone_select_enabled(zen),
    .zone_select_valid(zval), .offset_binary(ob), .gain_enable(gen),
    .applied_gain_code(gain));
  host_serial_model i_host (.ref_clk(ref_clk), .serial_readback_pin(pin),
    .serial_clk(sclk), .serial_enable_n(sen_n), .serial_data_in(sdi));
  // Core clock at 8 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task print_verdict;
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task apply;
    i_host.xfer(1'b0, 2'h2, 8'h00, 8'h01, q);
    i_host.xfer(1'b0, 2'h2, 8'h00, 8'h00, q);
  endtask : apply
  // A hung run still ends in the verdict.
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
  // Table first, then staging, apply, routing and a second reset.
  initial
  begin
    rst_n = 1'b0;
    fob = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i])
    begin
      i_host.xfer(1'b0, rows[i].pg, rows[i].ofs, rows[i].wd, q);
      i_host.xfer(1'b1, rows[i].pg, rows[i].ofs, 8'h00, q);
      chk("readback", rows[i].rd, q);
    end
    chk("staged coding", 8'h00, {7'h00, ob});
    chk("staged gain", 8'h20, {1'b0, gain});
    chk("perf top", 8'h01, {7'h00, perf});
    chk("level", 8'h55, level);
    apply();
    chk("highpass", 8'h01, {7'h00, hp});
    chk("zone", 8'h1A, {3'h0, zen, zval, zone});
    chk("coding", 8'h01, {7'h00, ob});
    chk("gain", 8'hFF, {gen, gain});
    i_host.xfer(1'b0, 2'h2, 8'h41, 8'h02, q);
    i_host.xfer(1'b0, 2'h2, 8'h4B, 8'h00, q);
    i_host.xfer(1'b0, 2'h2, 8'h52, 8'h00, q);
    i_host.xfer(1'b0, 2'h2, 8'h42, 8'h05, q);
    apply();
    chk("forbidden", 8'h01, {6'h00, hp, forb});
    chk("coding off", 8'h00, {7'h00, ob});
    chk("gain off", 8'h20, {gen, gain});
    chk("zone unused", 8'h15, {3'h0, zen, zval, zone});
    i_host.xfer(1'b0, 2'h0, 8'h59, 8'hA0, q);
    fob <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("routed", 8'h07, {5'h00, route, oe, pin});
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("reset level", 8'hE3, level);
    chk("reset gain", 8'h20, {1'b0, gain});
    chk("reset flags", 8'h00, {route, oe, pin, perf, zen, ob, gen, forb});
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    i_host.xfer(1'b1, 2'h2, 8'h41, 8'h00, q);
    chk("reset filter", 8'h02, q);
    print_verdict();
  end
endmodule : adc_digital_path_config_regs_test
